// ==== design/mdu_pkg.sv ====
// Constants and types shared by the multiplier/divider design
package mdu_pkg;

  // ************************************************************
  // Register addresses on the internal bus
  // ************************************************************
  localparam logic [15:0] MDU_ADDR_REM = 16'hFF60;
  localparam logic [15:0] MDU_ADDR_A_LOW = 16'hFF62;
  localparam logic [15:0] MDU_ADDR_A_HIGH = 16'hFF64;
  localparam logic [15:0] MDU_ADDR_B = 16'hFF66;
  localparam logic [15:0] MDU_ADDR_CTRL = 16'hFF68;

  // ************************************************************
  // Control register fields and reset values
  // ************************************************************
  localparam int MDU_CTRL_START_BIT = 7;
  localparam int MDU_CTRL_MODE_BIT = 0;
  localparam logic [7:0] MDU_CTRL_RESET = 8'h00;
  localparam logic [15:0] MDU_DATA_RESET = 16'h0000;
  localparam logic MDU_MODE_DIV = 1'b0;
  localparam logic MDU_MODE_MUL = 1'b1;

  // ************************************************************
  // Cycle counts of an operation
  // ************************************************************
  localparam logic [5:0] MDU_MUL_CYCLES = 6'h10;
  localparam logic [5:0] MDU_DIV_CYCLES = 6'h20;
  localparam logic [5:0] MDU_CNT_RESET = 6'h00;

  // ************************************************************
  // Bus access and sequencer state types
  // ************************************************************
  typedef enum logic [1:0] {
    MDU_SIZE_BYTE = 2'b00,
    MDU_SIZE_WORD = 2'b01,
    MDU_SIZE_BIT = 2'b10
  } mdu_size_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    mdu_size_t size;
    logic [2:0] bit_sel;
    logic wr;
    logic rd;
  } mdu_bus_req_t;

  typedef enum logic [1:0] {
    MDU_ST_IDLE = 2'b00,
    MDU_ST_RUN = 2'b01
  } mdu_state_t;

endpackage : mdu_pkg

// ==== design/mdu_step.sv ====
// One iteration of shift-and-add multiply or restoring divide
`timescale 1ns/10ps
module mdu_step
(
  // Mode
  input wire logic mode_mul,
  // Current datapath state
  input wire logic [31:0] a_in,
  input wire logic [15:0] rem_in,
  input wire logic [15:0] b_in,
  // Next datapath state
  output logic [31:0] a_out,
  output logic [15:0] rem_out
);

  localparam logic [15:0] MDU_ZERO16 = mdu_pkg::MDU_DATA_RESET;

  // ************************************************************
  // Multiply step
  // ************************************************************
  wire logic [16:0] mul_sum;
  wire logic [16:0] mul_add;
  wire logic [31:0] mul_a;

  // Add B into the high half when the low multiplier bit is set
  assign mul_add = a_in[0] ? {1'b0, b_in} : 17'h00000;
  assign mul_sum = {1'b0, a_in[31:16]} + mul_add;
  // Shift the carry, sum and remaining multiplier bits right
  assign mul_a = {mul_sum, a_in[15:1]};

  // ************************************************************
  // Divide step
  // ************************************************************
  wire logic [16:0] div_trial;
  wire logic [16:0] div_diff;
  wire logic div_fits;
  wire logic [15:0] div_rem;
  wire logic [31:0] div_a;

  // Bring the next dividend bit into the partial remainder
  assign div_trial = {rem_in, a_in[31]};
  assign div_diff = div_trial - {1'b0, b_in};
  assign div_fits = (div_trial >= {1'b0, b_in});
  // Restore on a miss, keep the difference on a hit
  assign div_rem = div_fits ? div_diff[15:0] : div_trial[15:0];
  assign div_a = {a_in[30:0], div_fits};

  // ************************************************************
  // Mode selection
  // ************************************************************
  assign a_out = mode_mul ? mul_a : div_a;
  assign rem_out = mode_mul ? MDU_ZERO16 : div_rem;

endmodule : mdu_step

// ==== design/mdu_core.sv ====
// Multiplier/divider with its memory-mapped registers
`timescale 1ns/10ps
module mdu_core
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register access from the processor
  input wire mdu_pkg::mdu_bus_req_t bus_req,
  output logic [15:0] bus_rdata_reg,
  // Completion request and status
  output logic op_done_irq,
  output logic op_busy
);

  // ************************************************************
  // Register storage
  // ************************************************************
  logic [15:0] operand_a_high_reg;
  logic [15:0] operand_a_low_reg;
  logic [15:0] operand_b_reg;
  logic [15:0] remainder_result_reg;
  logic op_start_reg;
  logic op_mode_select_reg;
  logic [5:0] count_reg;
  logic op_done_irq_reg;
  mdu_pkg::mdu_state_t state_reg;

  logic [15:0] operand_a_high_next;
  logic [15:0] operand_a_low_next;
  logic [15:0] operand_b_next;
  logic [15:0] remainder_result_next;
  logic op_start_next;
  logic op_mode_select_next;
  logic [5:0] count_next;
  logic op_done_irq_next;
  mdu_pkg::mdu_state_t state_next;
  logic [15:0] bus_rdata_next;

  // ************************************************************
  // Address decode
  // ************************************************************
  wire logic [15:0] word_addr;
  wire logic byte_hi;
  wire logic hit_rem;
  wire logic hit_a_low;
  wire logic hit_a_high;
  wire logic hit_b;
  wire logic hit_ctrl;

  // Word registers sit on even addresses, odd address is the high byte
  assign word_addr = {bus_req.addr[15:1], 1'b0};
  assign byte_hi = bus_req.addr[0] && (bus_req.size == mdu_pkg::MDU_SIZE_BYTE);
  assign hit_rem = (word_addr == mdu_pkg::MDU_ADDR_REM);
  assign hit_a_low = (word_addr == mdu_pkg::MDU_ADDR_A_LOW);
  assign hit_a_high = (word_addr == mdu_pkg::MDU_ADDR_A_HIGH);
  assign hit_b = (word_addr == mdu_pkg::MDU_ADDR_B);
  // Control is a byte register with a single address
  assign hit_ctrl = (bus_req.addr == mdu_pkg::MDU_ADDR_CTRL);

  // ************************************************************
  // Write strobes
  // ************************************************************
  wire logic data_access;
  wire logic ctrl_access;
  wire logic wr_a_low;
  wire logic wr_a_high;
  wire logic wr_b;
  wire logic wr_ctrl;

  // A and B registers take byte or word writes only; the remainder takes no writes
  assign data_access = (bus_req.size == mdu_pkg::MDU_SIZE_BYTE) ||
                       (bus_req.size == mdu_pkg::MDU_SIZE_WORD);
  // Control takes bit or byte writes only
  assign ctrl_access = (bus_req.size == mdu_pkg::MDU_SIZE_BYTE) ||
                       (bus_req.size == mdu_pkg::MDU_SIZE_BIT);
  assign wr_a_low = bus_req.wr && hit_a_low && data_access;
  assign wr_a_high = bus_req.wr && hit_a_high && data_access;
  assign wr_b = bus_req.wr && hit_b && data_access;
  assign wr_ctrl = bus_req.wr && hit_ctrl && ctrl_access;

  // ************************************************************
  // Byte or word merge for data registers
  // ************************************************************
  function automatic logic [15:0] mdu_merge(input logic [15:0] old_val,
                                            input logic [15:0] wdata,
                                            input logic is_word,
                                            input logic high_byte);
    logic [15:0] result;
    result = old_val;
    if (is_word)
    begin
      result = wdata;
    end
    else if (high_byte)
    begin
      result[15:8] = wdata[7:0];
    end
    else
    begin
      result[7:0] = wdata[7:0];
    end
    return result;
  endfunction : mdu_merge

  wire logic is_word;
  wire logic [15:0] a_low_wr_val;
  wire logic [15:0] a_high_wr_val;
  wire logic [15:0] b_wr_val;

  // Values that a software write would store
  assign is_word = (bus_req.size == mdu_pkg::MDU_SIZE_WORD);
  assign a_low_wr_val = mdu_merge(operand_a_low_reg, bus_req.wdata, is_word, byte_hi);
  assign a_high_wr_val = mdu_merge(operand_a_high_reg, bus_req.wdata, is_word, byte_hi);
  assign b_wr_val = mdu_merge(operand_b_reg, bus_req.wdata, is_word, byte_hi);

  // ************************************************************
  // Control register write decode
  // ************************************************************
  wire logic [7:0] ctrl_now;
  wire logic [7:0] ctrl_bit_mask;
  wire logic [7:0] ctrl_wr_val;
  wire logic ctrl_start_wr;
  wire logic ctrl_mode_wr;

  // Current control byte; unused bits always read zero
  assign ctrl_now = {op_start_reg, 6'h00, op_mode_select_reg};
  // A bit write touches one bit, a byte write all of them
  assign ctrl_bit_mask = 8'h01 << bus_req.bit_sel;
  assign ctrl_wr_val = (bus_req.size == mdu_pkg::MDU_SIZE_BIT) ?
                       (bus_req.wdata[0] ? (ctrl_now | ctrl_bit_mask)
                                         : (ctrl_now & ~ctrl_bit_mask))
                       : bus_req.wdata[7:0];
  assign ctrl_start_wr = ctrl_wr_val[mdu_pkg::MDU_CTRL_START_BIT];
  assign ctrl_mode_wr = ctrl_wr_val[mdu_pkg::MDU_CTRL_MODE_BIT];

  // ************************************************************
  // Sequencing events
  // ************************************************************
  wire logic running;
  wire logic start_op;
  wire logic last_step;
  wire logic abort_op;
  wire logic mode_mul_new;

  assign running = (state_reg == mdu_pkg::MDU_ST_RUN);
  // Setting the start bit from idle launches an operation
  assign start_op = wr_ctrl && ctrl_start_wr && !running;
  // Final step is taken when one step remains
  assign last_step = running && (count_reg == 6'h01);
  // Clearing the start bit mid-run stops it, unless it is the last step
  assign abort_op = running && wr_ctrl && !ctrl_start_wr && !last_step;
  // Mode taken for the operation being started
  assign mode_mul_new = ctrl_mode_wr;

  // ************************************************************
  // Arithmetic step
  // ************************************************************
  wire logic [31:0] step_a;
  wire logic [15:0] step_rem;

  // One iteration per clock while running
  mdu_step u_step
  (
    .mode_mul(op_mode_select_reg),
    .a_in({operand_a_high_reg, operand_a_low_reg}),
    .rem_in(remainder_result_reg),
    .b_in(operand_b_reg),
    .a_out(step_a),
    .rem_out(step_rem)
  );

  // ************************************************************
  // State and counter next values
  // ************************************************************
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    op_start_next = op_start_reg;
    op_done_irq_next = 1'b0;
    unique case (state_reg)
      mdu_pkg::MDU_ST_IDLE:
      begin
        if (start_op)
        begin
          state_next = mdu_pkg::MDU_ST_RUN;
          op_start_next = 1'b1;
          // Sixteen steps for multiply, thirty-two for divide
          count_next = (mode_mul_new == mdu_pkg::MDU_MODE_MUL) ?
                       mdu_pkg::MDU_MUL_CYCLES : mdu_pkg::MDU_DIV_CYCLES;
        end
      end
      mdu_pkg::MDU_ST_RUN:
      begin
        if (last_step)
        begin
          // Self-clear and one completion pulse together
          state_next = mdu_pkg::MDU_ST_IDLE;
          op_start_next = 1'b0;
          op_done_irq_next = 1'b1;
          count_next = mdu_pkg::MDU_CNT_RESET;
        end
        else if (abort_op)
        begin
          // Abandoned run gives no completion pulse
          state_next = mdu_pkg::MDU_ST_IDLE;
          op_start_next = 1'b0;
          count_next = mdu_pkg::MDU_CNT_RESET;
        end
        else
        begin
          count_next = count_reg - 6'h01;
        end
      end
    endcase
  end

  // ************************************************************
  // Mode bit next value
  // ************************************************************
  always_comb
  begin
    op_mode_select_next = op_mode_select_reg;
    // Bit 0 picks divide (0) or multiply (1)
    if (wr_ctrl)
    begin
      op_mode_select_next = ctrl_mode_wr;
    end
  end

  // ************************************************************
  // Datapath register next values
  // ************************************************************
  always_comb
  begin
    operand_a_high_next = operand_a_high_reg;
    operand_a_low_next = operand_a_low_reg;
    operand_b_next = operand_b_reg;
    remainder_result_next = remainder_result_reg;
    if (running)
    begin
      // Intermediate values are visible while the steps run
      operand_a_high_next = step_a[31:16];
      operand_a_low_next = step_a[15:0];
      remainder_result_next = step_rem;
      if (wr_b)
      begin
        operand_b_next = b_wr_val;
      end
    end
    else
    begin
      if (wr_a_low)
      begin
        operand_a_low_next = a_low_wr_val;
      end
      if (wr_a_high)
      begin
        operand_a_high_next = a_high_wr_val;
      end
      if (wr_b)
      begin
        operand_b_next = b_wr_val;
      end
      if (start_op)
      begin
        // Fresh operation begins with an empty remainder
        remainder_result_next = mdu_pkg::MDU_DATA_RESET;
        if (mode_mul_new == mdu_pkg::MDU_MODE_MUL)
        begin
          // Multiply starts with a cleared high half
          operand_a_high_next = mdu_pkg::MDU_DATA_RESET;
        end
      end
    end
  end

  // ************************************************************
  // Read data selection
  // ************************************************************
  wire logic [15:0] rd_word;
  wire logic [15:0] rd_sized;

  // Unmapped addresses read as zero
  assign rd_word = hit_ctrl ? {8'h00, ctrl_now} :
                   hit_rem ? remainder_result_reg :
                   hit_a_low ? operand_a_low_reg :
                   hit_a_high ? operand_a_high_reg :
                   hit_b ? operand_b_reg : 16'h0000;
  // Byte reads return the addressed byte in the low lane
  assign rd_sized = (bus_req.size == mdu_pkg::MDU_SIZE_WORD) ? rd_word :
                    (hit_ctrl ? {8'h00, ctrl_now} :
                     (byte_hi ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]}));

  always_comb
  begin
    bus_rdata_next = bus_rdata_reg;
    if (bus_req.rd)
    begin
      bus_rdata_next = rd_sized;
    end
  end

  // ************************************************************
  // Sequencer registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= mdu_pkg::MDU_ST_IDLE;
      count_reg <= mdu_pkg::MDU_CNT_RESET;
      op_start_reg <= mdu_pkg::MDU_CTRL_RESET[mdu_pkg::MDU_CTRL_START_BIT];
      op_mode_select_reg <= mdu_pkg::MDU_CTRL_RESET[mdu_pkg::MDU_CTRL_MODE_BIT];
      op_done_irq_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      op_start_reg <= op_start_next;
      op_mode_select_reg <= op_mode_select_next;
      op_done_irq_reg <= op_done_irq_next;
    end
  end

  // ************************************************************
  // Data registers
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      operand_a_high_reg <= mdu_pkg::MDU_DATA_RESET;
      operand_a_low_reg <= mdu_pkg::MDU_DATA_RESET;
      operand_b_reg <= mdu_pkg::MDU_DATA_RESET;
      remainder_result_reg <= mdu_pkg::MDU_DATA_RESET;
    end
    else
    begin
      operand_a_high_reg <= operand_a_high_next;
      operand_a_low_reg <= operand_a_low_next;
      operand_b_reg <= operand_b_next;
      remainder_result_reg <= remainder_result_next;
    end
  end

  // ************************************************************
  // Read data register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_rdata_reg <= mdu_pkg::MDU_DATA_RESET;
    end
    else
    begin
      bus_rdata_reg <= bus_rdata_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign op_done_irq = op_done_irq_reg;
  assign op_busy = op_start_reg;

endmodule : mdu_core

// ==== bench/mdu_cpu_model.sv ====
// Processor-side bus model that loads operands and starts operations
`timescale 1ns/10ps
module mdu_cpu_model
(
  // Clock
  input wire logic clk,
  // Register bus
  output mdu_pkg::mdu_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata_reg
);
  // Bus idle from time zero
  initial bus_req = '0;

  // ************************************************************
  // Bus cycles: drive after an edge, hold until the taking edge
  // ************************************************************
  task automatic access(input logic [15:0] addr, input logic [15:0] wdata,
    input mdu_pkg::mdu_size_t size, input logic [2:0] bit_sel, input logic wr,
    input logic rd, output logic [15:0] rdata);
  begin
    bus_req = '{addr: addr, wdata: wdata, size: size, bit_sel: bit_sel, wr: wr, rd: rd};
    @(posedge clk);
    #1;
    rdata = bus_rdata_reg;
  end
  endtask : access

  task automatic write(input logic [15:0] addr, input logic [15:0] data,
    input mdu_pkg::mdu_size_t size, input logic [2:0] bit_sel);
    logic [15:0] unused;
  begin
    access(addr, data, size, bit_sel, 1'h1, 1'h0, unused);
  end
  endtask : write

  task automatic read(input logic [15:0] addr, input mdu_pkg::mdu_size_t size,
    output logic [15:0] data);
  begin
    access(addr, 16'h0000, size, 3'h0, 1'h0, 1'h1, data);
  end
  endtask : read

  // Quiet cycles, slow software between accesses
  task automatic idle(input int cycles);
  begin
    repeat (cycles)
    begin
      bus_req = '0;
      @(posedge clk);
      #1;
    end
  end
  endtask : idle

  // Load operands, low half of A by bytes, then start by a byte write
  task automatic start_op(input logic mode, input logic [15:0] a_hi, input logic [15:0] a_lo,
    input logic [15:0] b);
  begin
    write(mdu_pkg::MDU_ADDR_A_HIGH, a_hi, mdu_pkg::MDU_SIZE_WORD, 3'h0);
    write(mdu_pkg::MDU_ADDR_A_LOW, {8'h00, a_lo[7:0]}, mdu_pkg::MDU_SIZE_BYTE, 3'h0);
    write(mdu_pkg::MDU_ADDR_A_LOW + 16'h0001, {8'h00, a_lo[15:8]}, mdu_pkg::MDU_SIZE_BYTE, 3'h0);
    write(mdu_pkg::MDU_ADDR_B, b, mdu_pkg::MDU_SIZE_WORD, 3'h0);
    write(mdu_pkg::MDU_ADDR_CTRL, {8'h00, 1'h1, 6'h00, mode}, mdu_pkg::MDU_SIZE_BYTE, 3'h0);
  end
  endtask : start_op
endmodule : mdu_cpu_model

// ==== bench/mdu_core_assertions.sv ====
// Port-level assertions for the multiplier/divider
`timescale 1ns/10ps
module mdu_core_assertions
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire mdu_pkg::mdu_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata_reg,
  // Status
  input wire logic op_done_irq,
  input wire logic op_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ************************************************************
  // Request decode
  // ************************************************************
  wire ctrl_wr = bus_req.wr && (bus_req.addr == mdu_pkg::MDU_ADDR_CTRL);
  wire ctrl_rd = bus_req.rd && (bus_req.addr == mdu_pkg::MDU_ADDR_CTRL);
  wire is_byte = bus_req.size == mdu_pkg::MDU_SIZE_BYTE;
  wire is_bit7 = (bus_req.size == mdu_pkg::MDU_SIZE_BIT) && (bus_req.bit_sel == 3'h7);
  wire start_req = ctrl_wr && ((is_byte && bus_req.wdata[7]) || (is_bit7 && bus_req.wdata[0]));
  wire clear_req = ctrl_wr && ((is_byte && !bus_req.wdata[7]) || (is_bit7 && !bus_req.wdata[0]));
  wire byte_start = ctrl_wr && is_byte && bus_req.wdata[7] && !op_busy;

  // Cycles since a byte start; tracking drops on a control write before the final step
  logic [5:0] run_cnt_reg;
  logic [5:0] run_len_reg;
  logic [5:0] run_cnt_next;
  assign run_cnt_next = byte_start ? 6'h01 :
    ((run_cnt_reg == 6'h00) || (run_cnt_reg > run_len_reg) ||
    (ctrl_wr && (run_cnt_reg < run_len_reg))) ? 6'h00 : run_cnt_reg + 6'h01;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_cnt_reg <= 6'h00;
      run_len_reg <= 6'h00;
    end
    else
    begin
      run_cnt_reg <= run_cnt_next;
      if (byte_start)
        run_len_reg <= bus_req.wdata[0] ? mdu_pkg::MDU_MUL_CYCLES : mdu_pkg::MDU_DIV_CYCLES;
    end
  end

  // ************************************************************
  // Operation timing
  // ************************************************************
  sequence s_mul_start;
    byte_start && bus_req.wdata[0];
  endsequence
  sequence s_mul_finish;
    op_busy ##1 (!op_busy && op_done_irq);
  endsequence
  a_mul_sixteen: assert property ((run_len_reg == mdu_pkg::MDU_MUL_CYCLES) &&
    (run_cnt_reg == mdu_pkg::MDU_MUL_CYCLES) |-> s_mul_finish)
    else $error("multiply did not finish on its sixteenth clock");
  a_mul_begins: assert property (s_mul_start |=> op_busy && !op_done_irq)
    else $error("multiply start did not set the start bit");
  a_busy_holds: assert property ((run_cnt_reg != 6'h00) && (run_cnt_reg <= run_len_reg)
    |-> op_busy && !op_done_irq) else $error("operation ended early");
  a_done_on_time: assert property ((run_len_reg != 6'h00) &&
    (run_cnt_reg == run_len_reg + 6'h01) |-> op_done_irq && !op_busy)
    else $error("operation not complete on time");
  a_abort_stops: assert property (clear_req && (run_cnt_reg != 6'h00) &&
    (run_cnt_reg < run_len_reg) |=> !op_busy ##1 !op_done_irq)
    else $error("abort did not stop the operation");
  a_final_clear: assert property (clear_req && (run_len_reg != 6'h00) &&
    (run_cnt_reg == run_len_reg) |=> op_done_irq) else $error("final step clear lost");
  a_irq_single: assert property (op_done_irq |=> !op_done_irq)
    else $error("completion request longer than one clock");
  a_irq_at_clear: assert property (op_done_irq |-> !op_busy && $past(op_busy))
    else $error("completion request without start bit clearing");
  a_start_only: assert property ($rose(op_busy) |-> $past(start_req))
    else $error("start bit set without a start write");
  a_ctrl_read: assert property (ctrl_rd |=>
    bus_rdata_reg[15:1] == {8'h00, $past(op_busy), 6'h00}) else $error("control read wrong");
  a_rdata_holds: assert property (!bus_req.rd |=> $stable(bus_rdata_reg))
    else $error("read data changed without a read");
endmodule : mdu_core_assertions

bind mdu_core mdu_core_assertions u_chk (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
  .bus_rdata_reg(bus_rdata_reg), .op_done_irq(op_done_irq), .op_busy(op_busy));

// ==== bench/test_mdu_core.sv ====
// Self-checking testbench for the multiplier/divider
`timescale 1ns/10ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module test_mdu_core;
  typedef struct packed {
    logic mode;
    logic [15:0] a_hi;
    logic [15:0] a_lo;
    logic [15:0] b;
    logic [31:0] q;
    logic [15:0] r;
  } mdu_row_t;
  // Operand rows beside the results they give; row 4 leaves A high dirty on purpose
  localparam mdu_row_t ROWS [7] = '{
    '{1'h0, 16'hFFFF, 16'hFFFF, 16'hFFFF, 32'h00010001, 16'h0000},
    '{1'h0, 16'h0000, 16'h0007, 16'h0003, 32'h00000002, 16'h0001},
    '{1'h0, 16'h0001, 16'h0000, 16'h0002, 32'h00008000, 16'h0000},
    '{1'h0, 16'h1234, 16'h5678, 16'h0100, 32'h00123456, 16'h0078},
    '{1'h1, 16'hFFFF, 16'hFFFF, 16'hFFFF, 32'hFFFE0001, 16'h0000},
    '{1'h1, 16'h0000, 16'h00DA, 16'h0093, 32'h00007D2E, 16'h0000},
    '{1'h1, 16'h0000, 16'h0000, 16'h1234, 32'h00000000, 16'h0000}};
  localparam logic [15:0] ADDRS [6] = '{mdu_pkg::MDU_ADDR_REM, mdu_pkg::MDU_ADDR_A_LOW,
    mdu_pkg::MDU_ADDR_A_HIGH, mdu_pkg::MDU_ADDR_B, mdu_pkg::MDU_ADDR_CTRL, 16'hFF6A};
  logic clk;
  logic rst_b;
  mdu_pkg::mdu_bus_req_t bus_req;
  logic [15:0] bus_rdata_reg;
  logic op_done_irq;
  logic op_busy;
  logic [15:0] rd;
  int checks;
  int bad_count;
  int n;

  // Design and processor model
  mdu_core uut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata_reg(bus_rdata_reg),
    .op_done_irq(op_done_irq), .op_busy(op_busy));
  mdu_cpu_model u_cpu (.clk(clk), .bus_req(bus_req), .bus_rdata_reg(bus_rdata_reg));

  // 200 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic wait_done(output int cyc);
  begin
    u_cpu.idle(1);
    cyc = 1;
    while (op_done_irq !== 1'h1 && cyc < 40)
    begin
      u_cpu.idle(1);
      cyc++;
    end
  end
  endtask : wait_done

  task automatic check_zero();
  begin
    foreach (ADDRS[i])
    begin
      u_cpu.read(ADDRS[i], (ADDRS[i] == mdu_pkg::MDU_ADDR_CTRL) ? mdu_pkg::MDU_SIZE_BYTE :
        mdu_pkg::MDU_SIZE_WORD, rd);
      `CHK("reset value", mdu_pkg::MDU_DATA_RESET, rd)
    end
  end
  endtask : check_zero

  task automatic wrap_up();
  begin
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask : wrap_up

  // Watchdog on a hung handshake
  initial
  begin
    #50000;
    bad_count++;
    $display("watchdog expired");
    wrap_up();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    checks = 0;
    bad_count = 0;
    rst_b = 1'h0;
    repeat (8) @(posedge clk);
    #1 rst_b = 1'h1;
    check_zero();
    $display("test reset values done");
    // Table of operations
    for (int i = 0; i < 7; i++)
    begin
      u_cpu.start_op(ROWS[i].mode, ROWS[i].a_hi, ROWS[i].a_lo, ROWS[i].b);
      wait_done(n);
      `CHK("cycles", ROWS[i].mode ? 16 : 32, n)
      u_cpu.read(mdu_pkg::MDU_ADDR_A_HIGH, mdu_pkg::MDU_SIZE_WORD, rd);
      `CHK("a_high", ROWS[i].q[31:16], rd)
      u_cpu.read(mdu_pkg::MDU_ADDR_A_LOW, mdu_pkg::MDU_SIZE_WORD, rd);
      `CHK("a_low", ROWS[i].q[15:0], rd)
      u_cpu.read(mdu_pkg::MDU_ADDR_REM, mdu_pkg::MDU_SIZE_WORD, rd);
      `CHK("remainder", ROWS[i].r, rd)
      u_cpu.read(mdu_pkg::MDU_ADDR_CTRL, mdu_pkg::MDU_SIZE_BYTE, rd);
      `CHK("control", {15'h0000, ROWS[i].mode}, rd)
      $display("test row %0d done", i);
    end
    // Abort a division after a few steps
    u_cpu.start_op(1'h0, 16'h1234, 16'h5678, 16'h0100);
    u_cpu.idle(4);
    u_cpu.write(mdu_pkg::MDU_ADDR_CTRL, 16'h0000, mdu_pkg::MDU_SIZE_BYTE, 3'h0);
    `CHK("busy after abort", 1'h0, op_busy)
    wait_done(n);
    `CHK("abort no request", 40, n)
    $display("test abort done");
    // Clear written on the final step still completes
    u_cpu.start_op(1'h1, 16'h0000, 16'h00DA, 16'h0093);
    u_cpu.idle(15);
    u_cpu.write(mdu_pkg::MDU_ADDR_CTRL, 16'h0001, mdu_pkg::MDU_SIZE_BYTE, 3'h0);
    `CHK("final clear request", 1'h1, op_done_irq)
    u_cpu.read(mdu_pkg::MDU_ADDR_A_LOW, mdu_pkg::MDU_SIZE_WORD, rd);
    `CHK("final clear product", 16'h7D2E, rd)
    $display("test final clear done");
    // Word write to control refused, then start by bit writes
    u_cpu.write(mdu_pkg::MDU_ADDR_A_LOW, 16'h0003, mdu_pkg::MDU_SIZE_WORD, 3'h0);
    u_cpu.write(mdu_pkg::MDU_ADDR_B, 16'h0005, mdu_pkg::MDU_SIZE_WORD, 3'h0);
    u_cpu.write(mdu_pkg::MDU_ADDR_CTRL, 16'h0081, mdu_pkg::MDU_SIZE_WORD, 3'h0);
    `CHK("word write ignored", 1'h0, op_busy)
    u_cpu.write(mdu_pkg::MDU_ADDR_CTRL, 16'h0001, mdu_pkg::MDU_SIZE_BIT, 3'h0);
    u_cpu.write(mdu_pkg::MDU_ADDR_CTRL, 16'h0001, mdu_pkg::MDU_SIZE_BIT, 3'h7);
    wait_done(n);
    `CHK("bit start cycles", 16, n)
    u_cpu.write(mdu_pkg::MDU_ADDR_REM, 16'hFFFF, mdu_pkg::MDU_SIZE_WORD, 3'h0);
    u_cpu.read(mdu_pkg::MDU_ADDR_A_LOW, mdu_pkg::MDU_SIZE_WORD, rd);
    `CHK("bit start product", 16'h000F, rd)
    u_cpu.read(mdu_pkg::MDU_ADDR_REM, mdu_pkg::MDU_SIZE_WORD, rd);
    `CHK("remainder read only", 16'h0000, rd)
    $display("test bit start done");
    // Reset in the middle of a division
    u_cpu.start_op(1'h0, 16'h1234, 16'h5678, 16'h0100);
    u_cpu.idle(3);
    rst_b = 1'h0;
    u_cpu.idle(2);
    rst_b = 1'h1;
    check_zero();
    $display("test reset mid-run done");
    wrap_up();
  end
endmodule : test_mdu_core
